// ==== bench/dac_cmd_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module dac_cmd_chk (
  // Clock and reset
  input wire logic        core_clk_i,
  input wire logic        reset_n_i,
  // Link pins
  input wire logic        frame_sync_n_i,
  input wire logic        serial_readback_out_o,
  input wire logic        serial_readback_oe_o,
  // Register contents
  input wire logic        input_bank_select_o,
  input wire logic        thermal_shutdown_en_o,
  input wire logic        power_down_o,
  input wire logic [13:0] offset_dac_zero_o,
  input wire logic [13:0] offset_dac_one_o,
  input wire logic [31:0] bank_select_o,
  // Channel writes
  input wire logic        chan_wr_o,
  input wire logic [4:0]  chan_wr_index_o,
  input wire logic [1:0]  chan_wr_kind_o
);
  logic       fs_q;
  logic [5:0] since;
  wire [62:0] globals = {input_bank_select_o, thermal_shutdown_en_o, power_down_o,
                         offset_dac_zero_o, offset_dac_one_o, bank_select_o};

  // Cycles since the frame sync pin rose, saturating so idle time never wraps
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fs_q  <= 1'b1;
      since <= 6'h3F;
    end else begin
      fs_q <= frame_sync_n_i;
      if (frame_sync_n_i && !fs_q) since <= 6'h00;
      else if (since != 6'h3F) since <= since + 6'h01;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence sync_rise;
    $rose(frame_sync_n_i);
  endsequence

  a_apply_after_rise: assert property ($changed(globals) |-> since inside {[6'h01:6'h0C]})
    else $error("global register changed outside the apply window");
  a_write_after_rise: assert property (chan_wr_o |-> since <= 6'h32)
    else $error("channel write outside the sweep window");
  a_quiet_at_rise: assert property (sync_rise |-> ##1 $stable(globals) ##1 $stable(globals))
    else $error("register changed before the frame was synchronised");
  a_bank_kind: assert property (chan_wr_o && !chan_wr_kind_o[1] |-> chan_wr_kind_o[0] == input_bank_select_o)
    else $error("data write went to the wrong input bank");
  a_sdo_released: assert property (!serial_readback_oe_o |-> !serial_readback_out_o)
    else $error("readback data active while output disabled");
  a_oe_rise_window: assert property ($rose(serial_readback_oe_o) |-> since inside {[6'h02:6'h0C]})
    else $error("readback enable rose away from a frame end");
  a_oe_fall_window: assert property ($fell(serial_readback_oe_o) |-> since inside {[6'h02:6'h0C]})
    else $error("readback enable fell away from a frame end");
  a_index_held: assert property ($changed(chan_wr_index_o) |-> chan_wr_o)
    else $error("channel index moved without a write strobe");
  c_readback: cover property ($rose(serial_readback_oe_o));
endmodule
bind dac_serial_command_decoder dac_cmd_chk chk (.core_clk_i, .reset_n_i, .frame_sync_n_i,
  .serial_readback_out_o, .serial_readback_oe_o, .input_bank_select_o, .thermal_shutdown_en_o,
  .power_down_o, .offset_dac_zero_o, .offset_dac_one_o, .bank_select_o, .chan_wr_o,
  .chan_wr_index_o, .chan_wr_kind_o);
`default_nettype wire

// ==== bench/dac_serial_command_decoder_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module dac_serial_command_decoder_tb_top;
  logic        core_clk_i = 1'b0;
  logic        reset_n_i  = 1'b0;
  logic        overtemp_i = 1'b0;
  wire logic   serial_clk_i, serial_data_i, frame_sync_n_i;
  logic        serial_readback_out_o, serial_readback_oe_o, chan_wr_o;
  logic        input_bank_select_o, thermal_shutdown_en_o, power_down_o;
  logic [13:0] offset_dac_zero_o, offset_dac_one_o;
  logic [31:0] bank_select_o;
  logic [4:0]  chan_wr_index_o;
  logic [1:0]  chan_wr_kind_o;
  logic [15:0] chan_wr_data_o;
  logic [23:0] rd;
  logic [62:0] g;
  logic [22:0] wq[$];
  int          fails, comparisons, a, i;
  logic [21:0] sp[6] = '{22'h02FFFF, 22'h03C123, 22'h06FF11, 22'h070022, 22'h08A533, 22'h090044};
  logic [23:0] rw[8] = '{24'h04FFFF, 24'h0AFFFF, 24'h3FFFFF, 24'h00FFFF, 24'hE8FFFF,
                         24'hC5FFFF, 24'h020000, 24'h020000};
  int          rn[8] = '{24, 24, 24, 24, 24, 24, 23, 25};
  wire logic   sdo_wire = serial_readback_oe_o ? serial_readback_out_o : 1'bz;
  wire [62:0]  glob = {input_bank_select_o, thermal_shutdown_en_o, power_down_o,
                       offset_dac_zero_o, offset_dac_one_o, bank_select_o};

  always #12.5 core_clk_i = ~core_clk_i;

  dac_serial_command_decoder dut (.core_clk_i, .reset_n_i, .serial_clk_i, .serial_data_i,
    .frame_sync_n_i, .serial_readback_out_o, .serial_readback_oe_o, .overtemp_i,
    .input_bank_select_o, .thermal_shutdown_en_o, .power_down_o, .offset_dac_zero_o,
    .offset_dac_one_o, .bank_select_o, .chan_wr_o, .chan_wr_index_o, .chan_wr_kind_o,
    .chan_wr_data_o);

  spi_host_model host (.core_clk_i, .readback_i(sdo_wire), .serial_clk_o(serial_clk_i),
    .serial_data_o(serial_data_i), .frame_sync_n_o(frame_sync_n_i));

  always @(posedge core_clk_i)
    if (chan_wr_o === 1'b1) wq.push_back({chan_wr_kind_o, chan_wr_index_o, chan_wr_data_o});

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Sweep of a group write takes up to about 40 clocks after the frame
  task automatic send(input logic [23:0] w, input int n);
    host.xfer(w, n, rd);
    repeat (45) @(negedge core_clk_i);
  endtask

  function automatic logic [31:0] amask(input logic [5:0] ad);
    logic [2:0] u, l;
    u = ad[5:3];
    l = ad[2:0];
    case (u)
      3'h0: amask = (l == 3'h0) ? 32'hFFFFFFFF : (l <= 3'h4) ? 32'hFF << (8 * (l - 1)) : 32'h0;
      3'h5: amask = 32'h00000000;
      3'h6: amask = 32'h01010101 << l;
      3'h7: amask = 32'h01010100 << l;
      default: amask = 32'h00000001 << (8 * (u - 1) + l);
    endcase
  endfunction

  // Strobes must come once per addressed channel, lowest index first
  task automatic expect_wr(input logic [1:0] k, input logic [31:0] m, input logic [15:0] d);
    int j;
    for (j = 0; j < 32; j++)
      if (m[j]) check(wq.size() ? wq.pop_front() : 23'h7FFFFF, {k, j[4:0], d});
    check(wq.size(), 0);
    wq.delete();
  endtask

  task automatic close_out;
    $display("Counts: %0d comparisons, %0d fails", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge core_clk_i);
    fails++;
    close_out();
  end

  initial begin
    repeat (3) @(negedge core_clk_i);
    reset_n_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    check(glob, 63'h0);
    for (a = 0; a < 64; a++) begin
      send({2'(a % 3 + 1), a[5:0], 16'hA500 | 16'(a)}, 24);
      expect_wr((a % 3 == 2) ? 2'h0 : (a % 3 == 1) ? 2'h2 : 2'h3, amask(a[5:0]), 16'hA500 | 16'(a));
    end
    send({2'h0, 6'h01, 16'h0007}, 24);
    check(glob[62:60], 3'h7);
    send({2'h3, 6'h09, 16'h1234}, 24);
    expect_wr(2'h1, 32'h00000002, 16'h1234);
    overtemp_i = 1'b1;
    send({2'h0, 6'h01, 16'hFFE2}, 24);
    check(glob[62:60], 3'h2);
    for (i = 0; i < 6; i++) send({2'h0, sp[i]}, 24);
    check(offset_dac_zero_o, 14'h3FFF);
    check(offset_dac_one_o, 14'h0123);
    check(bank_select_o, 32'h44332211);
    g = glob;
    for (i = 0; i < 8; i++) send(rw[i], rn[i]);
    check(glob, g);
    check(wq.size(), 0);
    send(24'h0B00FF, 24);
    check(bank_select_o, 32'hFFFFFFFF);
    send(24'h0BFF00, 24);
    check(bank_select_o, 32'h00000000);
    send(24'h0580FF, 24);
    send(24'h000000, 24);
    check(rd, 24'h000012);
    send(24'h058100, 24);
    send(24'h000000, 24);
    check(rd, 24'h003FFF);
    send(24'h056480, 24);
    send(24'h000000, 24);
    check(rd, 24'h00A509);
    check(serial_readback_oe_o, 1'b0);
    reset_n_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
    check(glob, 63'h0);
    reset_n_i = 1'b1;
    close_out();
  end
endmodule
`default_nettype wire

// ==== bench/spi_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // Pacing clock and readback wire
  input  wire logic core_clk_i,
  input  wire logic readback_i,
  // Link pins
  output var  logic serial_clk_o,
  output var  logic serial_data_o,
  output var  logic frame_sync_n_o
);
  initial begin
    serial_clk_o   = 1'b1;
    serial_data_o  = 1'b1;
    frame_sync_n_o = 1'b1;
  end

  // Clock idles high; 8 core cycles a bit gives the 200 ns link period
  task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] rd);
    int i;
    rd = 24'h000000;
    @(negedge core_clk_i);
    frame_sync_n_o = 1'b0;
    for (i = 0; i < n; i++) begin
      serial_data_o = w[23 - (i % 24)];
      repeat (2) @(negedge core_clk_i);
      rd = {rd[22:0], readback_i};
      serial_clk_o = 1'b0;
      repeat (4) @(negedge core_clk_i);
      serial_clk_o = 1'b1;
      repeat (2) @(negedge core_clk_i);
    end
    frame_sync_n_o = 1'b1;
    // No pull on the data line, so it must not keep showing the last bit
    serial_data_o = ~serial_data_o;
    repeat (12) @(negedge core_clk_i);
  endtask
endmodule
`default_nettype wire

// ==== rtl/channel_ram.v ====
`timescale 1ns/1ps
`default_nettype none

// Per-channel register store, one write and one registered read port
module channel_ram #(
  parameter ADDR_W = 7,
  parameter DATA_W = 16
) (
  // Clock
  input  wire              core_clk_i,
  // Write port
  input  wire              wr_en_i,
  input  wire [ADDR_W-1:0] wr_addr_i,
  input  wire [DATA_W-1:0] wr_data_i,
  // Read port
  input  wire [ADDR_W-1:0] rd_addr_i,
  output reg  [DATA_W-1:0] rd_data_o
);

  reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // No reset on the array; unwritten words read back unknown in simulation
  always @(posedge core_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end

endmodule

`default_nettype wire

// ==== rtl/dac_cmd_defs.vh ====
`ifndef DAC_CMD_DEFS_VH
`define DAC_CMD_DEFS_VH

// Serial word layout
`define WORD_BITS        24
`define MODE_HI          23
`define MODE_LO          22
`define ADDR_HI          21
`define ADDR_LO          16
`define DATA_HI          15
`define EDGE_CNT_W       5
`define EDGE_TARGET      5'h18

// Mode field codes
`define MODE_SPECIAL     2'h0
`define MODE_GAIN        2'h1
`define MODE_OFFSET      2'h2
`define MODE_DATA        2'h3

// Channel memory kinds
`define KIND_BANK_A      2'h0
`define KIND_BANK_B      2'h1
`define KIND_OFFSET      2'h2
`define KIND_GAIN        2'h3

// Special function codes
`define FN_NOP           6'h00
`define FN_CONTROL       6'h01
`define FN_OFS_ZERO      6'h02
`define FN_OFS_ONE       6'h03
`define FN_READBACK      6'h05
`define FN_SEL_ZERO      6'h06
`define FN_SEL_ONE       6'h07
`define FN_SEL_TWO       6'h08
`define FN_SEL_THREE     6'h09
`define FN_SEL_BLOCK     6'h0B

// Control register fields and reset
`define CTRL_OVERTEMP    4
`define CTRL_BANK_SEL    2
`define CTRL_THERM_EN    1
`define CTRL_POWER_DOWN  0
`define CTRL_RESET       5'h00

// Readback selection
`define RB_PREFIX_HI     15
`define RB_PREFIX_LO     13
`define RB_ADDR_HI       12
`define RB_ADDR_LO       7
`define RB_GLOBAL        3'h4
`define RB_G_CONTROL     6'h01
`define RB_G_OFS_ZERO    6'h02
`define RB_G_OFS_ONE     6'h03
`define RB_G_SEL_ZERO    6'h06
`define RB_G_SEL_ONE     6'h07
`define RB_G_SEL_TWO     6'h08
`define RB_G_SEL_THREE   6'h09

// Other reset values
`define OFS_RESET        14'h0000
`define SEL_RESET        8'h00

`endif

// ==== rtl/dac_serial_command_decoder.v ====
`timescale 1ns/1ps
`default_nettype none
`include "dac_cmd_defs.vh"
module dac_serial_command_decoder #(
  parameter DATA_WIDTH = 16
) (
  // Clock and reset
  input  wire        core_clk_i,
  input  wire        reset_n_i,
  // Serial link pins
  input  wire        serial_clk_i,
  input  wire        serial_data_i,
  input  wire        frame_sync_n_i,
  output reg         serial_readback_out_o,
  output reg         serial_readback_oe_o,
  // Status input from the analogue side
  input  wire        overtemp_i,
  // Control and global register contents
  output reg         input_bank_select_o,
  output reg         thermal_shutdown_en_o,
  output reg         power_down_o,
  output reg  [13:0] offset_dac_zero_o,
  output reg  [13:0] offset_dac_one_o,
  output reg  [31:0] bank_select_o,
  // Per-channel write strobe with its data
  output reg         chan_wr_o,
  output reg  [4:0]  chan_wr_index_o,
  output reg  [1:0]  chan_wr_kind_o,
  output reg  [15:0] chan_wr_data_o
);
  localparam PAD = 16 - DATA_WIDTH;
  localparam ST_IDLE  = 1'b0;
  localparam ST_SWEEP = 1'b1;
  // Channel mask for a six-bit address code
  function [31:0] addr_mask;
    input [5:0] addr;
    reg   [2:0] hi;
    reg   [2:0] lo;
    begin
      hi = addr[5:3];
      lo = addr[2:0];
      addr_mask = 32'h0000_0000;
      case (hi)
        3'h0: begin
          if (lo == 3'h0) begin
            addr_mask = 32'hFFFF_FFFF;
          end else if (lo <= 3'h4) begin
            addr_mask = 32'h0000_00FF << {lo - 3'h1, 3'h0};
          end
        end
        3'h1, 3'h2, 3'h3, 3'h4: begin
          addr_mask = 32'h0000_0001 << {hi - 3'h1, lo};
        end
        3'h6: begin
          addr_mask = {4{8'h01 << lo}};
        end
        3'h7: begin
          addr_mask = {{3{8'h01 << lo}}, 8'h00};
        end
        default: begin
          addr_mask = 32'h0000_0000;
        end
      endcase
    end
  endfunction
  // Link pin and overtemp synchronisers plus one history stage for edge finding
  reg [1:0] sclk_sync;
  reg [1:0] sdi_sync;
  reg [1:0] sync_sync;
  reg [1:0] otemp_sync;
  reg       sclk_prev;
  reg       sync_prev;
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sclk_sync  <= 2'h3;
      sdi_sync   <= 2'h0;
      sync_sync  <= 2'h3;
      otemp_sync <= 2'h0;
      sclk_prev  <= 1'b1;
      sync_prev  <= 1'b1;
    end else begin
      sclk_sync  <= {sclk_sync[0], serial_clk_i};
      sdi_sync   <= {sdi_sync[0], serial_data_i};
      sync_sync  <= {sync_sync[0], frame_sync_n_i};
      otemp_sync <= {otemp_sync[0], overtemp_i};
      sclk_prev  <= sclk_sync[1];
      sync_prev  <= sync_sync[1];
    end
  end
  wire in_frame    = ~sync_sync[1];
  wire sclk_fall   = sclk_prev & ~sclk_sync[1];
  wire frame_start = sync_prev & ~sync_sync[1];
  wire frame_end   = ~sync_prev & sync_sync[1];
  // Word capture on falling serial clock edges
  reg [`WORD_BITS-1:0]  shift_in;
  reg [`EDGE_CNT_W-1:0] edge_cnt;
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shift_in <= {`WORD_BITS{1'b0}};
      edge_cnt <= {`EDGE_CNT_W{1'b0}};
    end else if (frame_start) begin
      edge_cnt <= {`EDGE_CNT_W{1'b0}};
    end else if (in_frame && sclk_fall) begin
      shift_in <= {shift_in[`WORD_BITS-2:0], sdi_sync[1]};
      // Saturate one past the target so an overlong frame is seen as corrupt
      if (edge_cnt <= `EDGE_TARGET) begin
        edge_cnt <= edge_cnt + 5'h01;
      end
    end
  end
  // Short or overlong frames are dropped
  wire word_ok = frame_end && (edge_cnt == `EDGE_TARGET);
  wire [1:0]  mode    = shift_in[`MODE_HI:`MODE_LO];
  wire [5:0]  address = shift_in[`ADDR_HI:`ADDR_LO];
  wire [15:0] operand = shift_in[`DATA_HI:0];
  wire [15:0] data_val = operand >> PAD;
  wire        is_special = (mode == `MODE_SPECIAL);
  // Global registers
  reg [4:0] control;
  reg [7:0] sel_reg [0:3];
  reg       rb_start;
  reg [2:0] rb_prefix;
  reg [5:0] rb_addr;
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      control           <= `CTRL_RESET;
      offset_dac_zero_o <= `OFS_RESET;
      offset_dac_one_o  <= `OFS_RESET;
      sel_reg[0]        <= `SEL_RESET;
      sel_reg[1]        <= `SEL_RESET;
      sel_reg[2]        <= `SEL_RESET;
      sel_reg[3]        <= `SEL_RESET;
      rb_start          <= 1'b0;
      rb_prefix         <= 3'h0;
      rb_addr           <= 6'h00;
    end else begin
      rb_start <= 1'b0;
      control[`CTRL_OVERTEMP] <= otemp_sync[1];
      if (word_ok && is_special) begin
        case (address)
          `FN_CONTROL: begin
            control[`CTRL_BANK_SEL]   <= operand[2];
            control[`CTRL_THERM_EN]   <= operand[1];
            control[`CTRL_POWER_DOWN] <= operand[0];
          end
          `FN_OFS_ZERO:  offset_dac_zero_o <= operand[13:0];
          `FN_OFS_ONE:   offset_dac_one_o  <= operand[13:0];
          `FN_SEL_ZERO:  sel_reg[0] <= operand[7:0];
          `FN_SEL_ONE:   sel_reg[1] <= operand[7:0];
          `FN_SEL_TWO:   sel_reg[2] <= operand[7:0];
          `FN_SEL_THREE: sel_reg[3] <= operand[7:0];
          `FN_SEL_BLOCK: begin
            sel_reg[0] <= operand[7:0];
            sel_reg[1] <= operand[7:0];
            sel_reg[2] <= operand[7:0];
            sel_reg[3] <= operand[7:0];
          end
          `FN_READBACK: begin
            rb_start  <= 1'b1;
            rb_prefix <= operand[`RB_PREFIX_HI:`RB_PREFIX_LO];
            rb_addr   <= operand[`RB_ADDR_HI:`RB_ADDR_LO];
          end
          default: begin
            // No-op and reserved codes leave everything alone
          end
        endcase
      end
    end
  end
  // Bit 3 is never stored, so it always reads as zero
  wire [7:0] ctrl_read = {3'h0, control[`CTRL_OVERTEMP], 1'b0, control[2:0]};
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      input_bank_select_o   <= 1'b0;
      thermal_shutdown_en_o <= 1'b0;
      power_down_o          <= 1'b0;
      bank_select_o         <= 32'h0000_0000;
    end else begin
      input_bank_select_o   <= control[`CTRL_BANK_SEL];
      thermal_shutdown_en_o <= control[`CTRL_THERM_EN];
      power_down_o          <= control[`CTRL_POWER_DOWN];
      bank_select_o         <= {sel_reg[3], sel_reg[2], sel_reg[1], sel_reg[0]};
    end
  end
  // Multi-channel write sweep: one channel per clock, 32 clocks a word.
  // A 24-bit frame takes far longer, so the sweep always ends before the next.
  reg        state;
  reg [4:0]  sweep_idx;
  reg [31:0] sweep_mask;
  reg [1:0]  sweep_kind;
  reg [15:0] sweep_data;
  reg [1:0]  next_kind;
  always @* begin
    case (mode)
      `MODE_DATA:   next_kind = control[`CTRL_BANK_SEL] ? `KIND_BANK_B
                                                        : `KIND_BANK_A;
      `MODE_OFFSET: next_kind = `KIND_OFFSET;
      `MODE_GAIN:   next_kind = `KIND_GAIN;
      default:      next_kind = `KIND_BANK_A;
    endcase
  end
  wire sweep_hit = (state == ST_SWEEP) && sweep_mask[sweep_idx];
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state      <= ST_IDLE;
      sweep_idx  <= 5'h00;
      sweep_mask <= 32'h0000_0000;
      sweep_kind <= `KIND_BANK_A;
      sweep_data <= 16'h0000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (word_ok && !is_special) begin
            state      <= ST_SWEEP;
            sweep_idx  <= 5'h00;
            sweep_mask <= addr_mask(address);
            sweep_kind <= next_kind;
            sweep_data <= data_val;
          end
        end
        ST_SWEEP: begin
          sweep_idx <= sweep_idx + 5'h01;
          if (sweep_idx == 5'h1F) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      chan_wr_o       <= 1'b0;
      chan_wr_index_o <= 5'h00;
      chan_wr_kind_o  <= 2'h0;
      chan_wr_data_o  <= 16'h0000;
    end else begin
      chan_wr_o <= sweep_hit;
      if (sweep_hit) begin
        chan_wr_index_o <= sweep_idx;
        chan_wr_kind_o  <= sweep_kind;
        chan_wr_data_o  <= sweep_data;
      end
    end
  end
  // Readback: single-channel code only; broadcast codes read as zero
  wire       rb_chan_ok = (rb_addr[5:3] >= 3'h1) && (rb_addr[5:3] <= 3'h4);
  wire [2:0] rb_group   = rb_addr[5:3] - 3'h1;
  wire [4:0] rb_index   = {rb_group[1:0], rb_addr[2:0]};
  wire [15:0] ram_rdata;
  channel_ram #(
    .ADDR_W (7),
    .DATA_W (16)
  ) u_ram (
    .core_clk_i (core_clk_i),
    .wr_en_i    (sweep_hit),
    .wr_addr_i  ({sweep_kind, sweep_idx}),
    .wr_data_i  (sweep_data),
    .rd_addr_i  ({rb_prefix[1:0], rb_index}),
    .rd_data_o  (ram_rdata)
  );
  reg [15:0] rb_value;
  always @* begin
    rb_value = 16'h0000;
    if (rb_prefix[2] == 1'b0) begin
      if (rb_chan_ok) begin
        rb_value = ram_rdata;
      end
    end else if (rb_prefix == `RB_GLOBAL) begin
      case (rb_addr)
        `RB_G_CONTROL:   rb_value = {8'h00, ctrl_read};
        `RB_G_OFS_ZERO:  rb_value = {2'h0, offset_dac_zero_o};
        `RB_G_OFS_ONE:   rb_value = {2'h0, offset_dac_one_o};
        `RB_G_SEL_ZERO:  rb_value = {8'h00, sel_reg[0]};
        `RB_G_SEL_ONE:   rb_value = {8'h00, sel_reg[1]};
        `RB_G_SEL_TWO:   rb_value = {8'h00, sel_reg[2]};
        `RB_G_SEL_THREE: rb_value = {8'h00, sel_reg[3]};
        default:         rb_value = 16'h0000;
      endcase
    end
  end
  // Load waits one clock so the registered RAM data follows the new address
  reg                  rb_load;
  reg                  rb_armed;
  reg [`WORD_BITS-1:0] shift_out;
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rb_load               <= 1'b0;
      rb_armed              <= 1'b0;
      shift_out             <= {`WORD_BITS{1'b0}};
      serial_readback_out_o <= 1'b0;
      serial_readback_oe_o  <= 1'b0;
    end else begin
      rb_load <= rb_start;
      serial_readback_out_o <= serial_readback_oe_o ? shift_out[`WORD_BITS-1] : 1'b0;
      if (rb_load) begin
        shift_out            <= {8'h00, rb_value};
        rb_armed             <= 1'b1;
        serial_readback_oe_o <= 1'b1;
      end else if (frame_end && rb_armed) begin
        // Release only after the frame that carried the data out
        rb_armed              <= 1'b0;
        serial_readback_oe_o  <= 1'b0;
        serial_readback_out_o <= 1'b0;
      end else if (rb_armed && in_frame && sclk_fall) begin
        shift_out <= {shift_out[`WORD_BITS-2:0], 1'b0};
      end
    end
  end
endmodule
`default_nettype wire
